// [hw/lsr_master.sv]
// Master end: sends a preparing frame, then one or two reading frames
`timescale 1ns/1ns
module lsr_master (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   lsr_link_if.master       link,
   input  wire logic        reqValid,
   input  wire logic        reqParam,
   input  wire logic        reqLong,
   input  wire logic        reqSecond,
   input  wire logic [6:0]  reqAddr,
   input  wire logic [5:0]  reqDirectId,
   output      logic        reqReady,
   output      logic        rspValid,
   output      logic        rspGood,
   output      logic        rspNoAnswer,
   output      logic        rspIsSecond,
   output      logic [63:0] rspData
);

   typedef struct packed {
      lsr_pkg::lsr_m_state_t st;
      logic [7:0]            pid;
      logic [63:0]           tx;
      logic [3:0]            len;
      logic [3:0]            cnt;
      logic [7:0]            sum;
      logic [7:0]            tmo;
      logic                  wantSecond;
      logic                  second;
      logic                  hValid;
      logic [7:0]            hPid;
      logic                  bValid;
      logic [7:0]            bData;
      logic                  oValid;
      logic                  oGood;
      logic                  oNone;
      logic                  oSecond;
      logic [63:0]           oData;
   } lsr_m_t;

   lsr_m_t m_r;
   lsr_m_t m_nxt;
   logic [7:0] cmdByte;

   assign cmdByte = reqParam ? lsr_pkg::CMD_PARAM : lsr_pkg::CMD_FULL;

   // Frame sequencer
   always_comb begin
      m_nxt        = m_r;
      m_nxt.hValid = 1'b0;
      m_nxt.bValid = 1'b0;
      m_nxt.oValid = 1'b0;
      case (m_r.st)
         lsr_pkg::M_IDLE: begin
            if (reqValid) begin
               m_nxt.st         = lsr_pkg::M_PHDR;
               m_nxt.wantSecond = reqSecond & ~reqParam;
               m_nxt.second     = 1'b0;
               if (reqLong) begin
                  m_nxt.pid = lsr_pkg::PID_PREP;
                  m_nxt.len = lsr_pkg::LEN_LONG;
                  m_nxt.tx  = {lsr_pkg::APP_CMD, cmdByte, lsr_pkg::ADDR_FLAG, reqAddr,
                               {5{lsr_pkg::FILL_BYTE}}};
               end else begin
                  m_nxt.pid = lsr_pkg::pid_of(reqDirectId);
                  m_nxt.len = lsr_pkg::LEN_SHORT;
                  m_nxt.tx  = {cmdByte, lsr_pkg::ADDR_FLAG, reqAddr, 48'h0};
               end
            end
         end
         lsr_pkg::M_PHDR: begin
            m_nxt.hValid = 1'b1;
            m_nxt.hPid   = m_r.pid;
            m_nxt.cnt    = '0;
            m_nxt.sum    = '0;
            m_nxt.st     = lsr_pkg::M_PDATA;
         end
         lsr_pkg::M_PDATA: begin
            m_nxt.bValid = 1'b1;
            if (m_r.cnt == m_r.len) begin
               m_nxt.bData = ~m_r.sum;
               m_nxt.st    = lsr_pkg::M_RHDR;
            end else begin
               m_nxt.bData = m_r.tx[63:56];
               m_nxt.sum   = lsr_pkg::csum_add(m_r.sum, m_r.tx[63:56]);
               m_nxt.tx    = {m_r.tx[55:0], 8'h00};
               m_nxt.cnt   = m_r.cnt + lsr_pkg::CNT_ONE;
            end
         end
         lsr_pkg::M_RHDR: begin
            m_nxt.hValid = 1'b1;
            m_nxt.hPid   = lsr_pkg::PID_READ;
            m_nxt.cnt    = '0;
            m_nxt.sum    = '0;
            m_nxt.tmo    = '0;
            m_nxt.oData  = '0;
            m_nxt.st     = lsr_pkg::M_RWAIT;
         end
         lsr_pkg::M_RWAIT: begin
            m_nxt.tmo = m_r.tmo + 8'h01;
            if (link.sByteValid) begin
               m_nxt.tmo = '0;
               if (m_r.cnt == lsr_pkg::LEN_RSP) begin
                  m_nxt.oValid  = 1'b1;
                  m_nxt.oGood   = (link.sByteData == ~m_r.sum);
                  m_nxt.oNone   = 1'b0;
                  m_nxt.oSecond = m_r.second;
                  m_nxt.st      = (m_r.wantSecond && !m_r.second) ?
                                  lsr_pkg::M_RHDR : lsr_pkg::M_IDLE;
                  m_nxt.second  = 1'b1;
               end else begin
                  m_nxt.oData = {m_r.oData[55:0], link.sByteData};
                  m_nxt.sum   = lsr_pkg::csum_add(m_r.sum, link.sByteData);
                  m_nxt.cnt   = m_r.cnt + lsr_pkg::CNT_ONE;
               end
            end else if (m_r.tmo == lsr_pkg::RSP_TIMEOUT_CYC) begin
               // Silent slave ends the transaction, no retry
               m_nxt.oValid  = 1'b1;
               m_nxt.oGood   = 1'b0;
               m_nxt.oNone   = 1'b1;
               m_nxt.oSecond = m_r.second;
               m_nxt.st      = lsr_pkg::M_IDLE;
            end
         end
         default: m_nxt.st = lsr_pkg::M_IDLE;
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         m_r <= '0;
      end else begin
         m_r <= m_nxt;
      end
   end

   assign reqReady        = (m_r.st == lsr_pkg::M_IDLE);
   assign link.hdrValid   = m_r.hValid;
   assign link.hdrPid     = m_r.hPid;
   assign link.mByteValid = m_r.bValid;
   assign link.mByteData  = m_r.bData;
   assign rspValid        = m_r.oValid;
   assign rspGood         = m_r.oGood;
   assign rspNoAnswer     = m_r.oNone;
   assign rspIsSecond     = m_r.oSecond;
   assign rspData         = m_r.oData;

endmodule

// [hw/lsr_slave.sv]
// Slave end: decodes preparing frames and answers reading frames
//
// Notes on behaviour
// - Master sends long preparing frame, then reading frame
// - Long frame: 0x3C, app byte, command, address, fill
// - Answer id 0x3D only after matching preparing
// - Byte five holds latched fault flags, temperature
// - Byte six: motion, switch, overcurrents, one, pump
// - Byte seven ones plus link errors; eight 0xFF
// - Second status: address, positions, secure position split
// - Direct preparing id carries two parity bits
// - Short preparing: command two, address, then reading
// - Reading returns parameter memory of named node
// - Param bytes one, two: trims with constant one
// - Param byte six, seven: secure position, shaft, accel
// - Param byte eight: step mode and lock bits
// - Full status read clears latched fault flags
// - Second status reading frame is optional
// - Address pin bits are live, not stored
`timescale 1ns/1ns
module lsr_slave (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   lsr_link_if.slave                link,
   input  wire logic [6:0]          nodeAddr,
   input  wire logic [5:0]          directId,
   input  wire lsr_pkg::lsr_status_t status,
   input  wire lsr_pkg::lsr_param_t  param,
   input  wire logic [2:0]          addressPinState,
   output      logic                clearFlags,
   output      logic                pendingRead
);

   typedef struct packed {
      lsr_pkg::lsr_sl_state_t st;
      lsr_pkg::lsr_pend_t     pend;
      logic                   isLong;
      logic [3:0]             cnt;
      logic [7:0]             sum;
      logic [7:0]             cmd;
      logic                   ok;
      lsr_pkg::lsr_pend_t     served;
      logic [63:0]            rsp;
      logic                   txValid;
      logic [7:0]             txData;
      logic                   clr;
   } lsr_sl_t;

   lsr_sl_t s_r;
   lsr_sl_t s_nxt;

   logic [63:0] fs1Bytes;
   logic [63:0] fs2Bytes;
   logic [63:0] prmBytes;
   logic [3:0]  pos;
   logic [3:0]  len;
   logic [7:0]  b;

   // Local alias keeps the byte maps compact; declared before its first use
   localparam logic ADDR_FLAG = lsr_pkg::ADDR_FLAG;

   // First full status answer, byte one in the top lane
   assign fs1Bytes = {ADDR_FLAG, nodeAddr,
                      status.runCurrent, status.holdCurrent,
                      status.maxVelocity, status.minVelocity,
                      status.accelerationShape, status.stepResolution,
                      status.shaft, status.acceleration,
                      status.logicSupplyResetFlag, status.lostStepFlag,
                      status.coilDefectFlag, status.secondUndervoltageFlag,
                      status.thermalShutdownFlag, status.thermalWarningFlag,
                      status.tempInfo,
                      status.motion, status.motionSwitchState,
                      status.coilXOvercurrent, status.coilYOvercurrent,
                      lsr_pkg::CONST_ONE, status.chargePumpFailure,
                      lsr_pkg::ONES4, status.linkTimeoutError,
                      status.linkDataError, status.linkHeaderError,
                      status.linkBitError,
                      lsr_pkg::FILL_BYTE};

   // Second answer; secure position goes low byte first
   assign fs2Bytes = {ADDR_FLAG, nodeAddr,
                      status.actualPosition,
                      status.targetPosition,
                      status.securePosition[7:0],
                      lsr_pkg::ONES5, status.securePosition[10:8],
                      lsr_pkg::FILL_BYTE};

   // Parameter memory image; pin bits sampled live
   assign prmBytes = {param.oscillatorTrim, param.currentReferenceTrim,
                      lsr_pkg::CONST_ONE, param.thermalShutdownTrim,
                      param.bandgapTrim,
                      param.addressModeBit, addressPinState,
                      param.programmedAddress,
                      param.runCurrent, param.holdCurrent,
                      param.maxVelocity, param.minVelocity,
                      param.securePosition[10:8], param.shaft,
                      param.acceleration,
                      param.securePosition[7:0],
                      lsr_pkg::ONES4, param.stepResolution,
                      param.trimLockBit, param.configLockBit};

   // Short frames lack the app byte, so shift them onto long positions
   assign len = s_r.isLong ? lsr_pkg::LEN_LONG : lsr_pkg::LEN_SHORT;
   assign pos = s_r.isLong ? s_r.cnt : s_r.cnt + lsr_pkg::SHORT_SKIP;
   assign b   = link.mByteData;

   // Next-state logic; a new header always restarts decoding
   always_comb begin
      s_nxt         = s_r;
      s_nxt.txValid = 1'b0;
      s_nxt.clr     = 1'b0;
      if (link.hdrValid) begin
         s_nxt.cnt = '0;
         s_nxt.sum = '0;
         s_nxt.ok  = 1'b1;
         s_nxt.cmd = '0;
         if (link.hdrPid == lsr_pkg::PID_PREP) begin
            s_nxt.st     = lsr_pkg::SL_RX;
            s_nxt.isLong = 1'b1;
         end else if (link.hdrPid == lsr_pkg::pid_of(directId)) begin
            s_nxt.st     = lsr_pkg::SL_RX;
            s_nxt.isLong = 1'b0;
         end else if (link.hdrPid == lsr_pkg::PID_READ &&
                      s_r.pend != lsr_pkg::PD_NONE) begin
            s_nxt.st     = lsr_pkg::SL_TX;
            s_nxt.served = s_r.pend;
            case (s_r.pend)
               lsr_pkg::PD_FS1:   s_nxt.rsp = fs1Bytes;
               lsr_pkg::PD_FS2:   s_nxt.rsp = fs2Bytes;
               lsr_pkg::PD_PARAM: s_nxt.rsp = prmBytes;
               default:           s_nxt.rsp = '0;
            endcase
         end else begin
            // Foreign frames and unprepared reads stay silent
            s_nxt.st = lsr_pkg::SL_IDLE;
         end
      end else begin
         case (s_r.st)
            lsr_pkg::SL_RX: begin
               if (link.mByteValid) begin
                  if (s_r.cnt == len) begin
                     // Checksum byte closes the preparing frame
                     s_nxt.st = lsr_pkg::SL_IDLE;
                     if (b == ~s_r.sum) begin
                        if (s_r.ok && s_r.cmd == lsr_pkg::CMD_FULL) begin
                           s_nxt.pend = lsr_pkg::PD_FS1;
                        end else if (s_r.ok && s_r.cmd == lsr_pkg::CMD_PARAM) begin
                           s_nxt.pend = lsr_pkg::PD_PARAM;
                        end else begin
                           s_nxt.pend = lsr_pkg::PD_NONE;
                        end
                     end
                  end else begin
                     s_nxt.sum = lsr_pkg::csum_add(s_r.sum, b);
                     s_nxt.cnt = s_r.cnt + lsr_pkg::CNT_ONE;
                     case (pos)
                        lsr_pkg::POS_APP: begin
                           if (b != lsr_pkg::APP_CMD) begin
                              s_nxt.ok = 1'b0;
                           end
                        end
                        lsr_pkg::POS_CMD: begin
                           s_nxt.cmd = b;
                        end
                        lsr_pkg::POS_ADDR: begin
                           if (b != {ADDR_FLAG, nodeAddr}) begin
                              s_nxt.ok = 1'b0;
                           end
                        end
                        default: begin
                           if (b != lsr_pkg::FILL_BYTE) begin
                              s_nxt.ok = 1'b0;
                           end
                        end
                     endcase
                  end
               end
            end
            lsr_pkg::SL_TX: begin
               s_nxt.txValid = 1'b1;
               if (s_r.cnt == lsr_pkg::LEN_RSP) begin
                  s_nxt.txData = ~s_r.sum;
                  s_nxt.st     = lsr_pkg::SL_IDLE;
                  // Second status answer may never be asked for
                  case (s_r.served)
                     lsr_pkg::PD_FS1: begin
                        s_nxt.pend = lsr_pkg::PD_FS2;
                        s_nxt.clr  = 1'b1;
                     end
                     default: s_nxt.pend = lsr_pkg::PD_NONE;
                  endcase
               end else begin
                  s_nxt.txData = s_r.rsp[63:56];
                  s_nxt.sum    = lsr_pkg::csum_add(s_r.sum, s_r.rsp[63:56]);
                  s_nxt.rsp    = {s_r.rsp[55:0], 8'h00};
                  s_nxt.cnt    = s_r.cnt + lsr_pkg::CNT_ONE;
               end
            end
            default: s_nxt.st = lsr_pkg::SL_IDLE;
         endcase
      end
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.sByteValid = s_r.txValid;
   assign link.sByteData  = s_r.txData;
   assign clearFlags      = s_r.clr;
   assign pendingRead     = (s_r.pend != lsr_pkg::PD_NONE);   // Compare on the registered pend field, so no input reaches it combinationally

endmodule

// [inc/lsr_link_if.sv]
// Byte-level frame link between bus master and motor controller slave
`timescale 1ns/1ns
interface lsr_link_if;
   logic       hdrValid;
   logic [7:0] hdrPid;
   logic       mByteValid;
   logic [7:0] mByteData;
   logic       sByteValid;
   logic [7:0] sByteData;

   modport master (output hdrValid, output hdrPid, output mByteValid, output mByteData,
                   input sByteValid, input sByteData);
   modport slave  (input hdrValid, input hdrPid, input mByteValid, input mByteData,
                   output sByteValid, output sByteData);
endinterface

// [inc/lsr_pkg.sv]
// Shared constants, types and helpers for the status and parameter readout link
package lsr_pkg;

   // Clock and answer timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RSP_TIMEOUT_NS = 200;
   localparam logic [7:0] RSP_TIMEOUT_CYC = 8'(RSP_TIMEOUT_NS / CLK_PERIOD_NS);

   // Identifiers and command bytes
   localparam logic [7:0] PID_PREP    = 8'h3C;   // Long preparing frame
   localparam logic [7:0] PID_READ    = 8'h7D;   // Reading frame, indirect id 0x3D
   localparam logic [7:0] APP_CMD     = 8'h80;
   localparam logic [7:0] CMD_FULL    = 8'h81;   // Flag bit set, code 0x01
   localparam logic [7:0] CMD_PARAM   = 8'h82;   // Flag bit set, code 0x02
   localparam logic       ADDR_FLAG   = 1'h1;
   localparam logic [7:0] FILL_BYTE   = 8'hFF;
   localparam logic [3:0] ONES4       = 4'hF;
   localparam logic [4:0] ONES5       = 5'h1F;
   localparam logic       CONST_ONE   = 1'h1;

   // Frame lengths and byte positions in a long preparing frame
   localparam logic [3:0] LEN_LONG    = 4'h8;
   localparam logic [3:0] LEN_SHORT   = 4'h2;
   localparam logic [3:0] LEN_RSP     = 4'h8;
   localparam logic [3:0] POS_APP     = 4'h0;
   localparam logic [3:0] POS_CMD     = 4'h1;
   localparam logic [3:0] POS_ADDR    = 4'h2;
   localparam logic [3:0] SHORT_SKIP  = 4'h1;
   localparam logic [3:0] CNT_ONE     = 4'h1;

   typedef enum logic [1:0] {SL_IDLE, SL_RX, SL_TX} lsr_sl_state_t;
   typedef enum logic [1:0] {PD_NONE, PD_FS1, PD_FS2, PD_PARAM} lsr_pend_t;
   typedef enum logic [2:0] {M_IDLE, M_PHDR, M_PDATA, M_RHDR, M_RWAIT} lsr_m_state_t;

   // Live motor and diagnostic state offered by the device core
   typedef struct packed {
      logic [3:0]  runCurrent;
      logic [3:0]  holdCurrent;
      logic [3:0]  maxVelocity;
      logic [3:0]  minVelocity;
      logic        accelerationShape;
      logic [1:0]  stepResolution;
      logic        shaft;
      logic [3:0]  acceleration;
      logic        logicSupplyResetFlag;
      logic        lostStepFlag;
      logic        coilDefectFlag;
      logic        secondUndervoltageFlag;
      logic        thermalShutdownFlag;
      logic        thermalWarningFlag;
      logic [1:0]  tempInfo;
      logic [2:0]  motion;
      logic        motionSwitchState;
      logic        coilXOvercurrent;
      logic        coilYOvercurrent;
      logic        chargePumpFailure;
      logic        linkTimeoutError;
      logic        linkDataError;
      logic        linkHeaderError;
      logic        linkBitError;
      logic [15:0] actualPosition;
      logic [15:0] targetPosition;
      logic [10:0] securePosition;
   } lsr_status_t;

   // Parameter memory contents
   typedef struct packed {
      logic [3:0]  oscillatorTrim;
      logic [3:0]  currentReferenceTrim;
      logic [2:0]  thermalShutdownTrim;
      logic [3:0]  bandgapTrim;
      logic        addressModeBit;
      logic [3:0]  programmedAddress;
      logic [3:0]  runCurrent;
      logic [3:0]  holdCurrent;
      logic [3:0]  maxVelocity;
      logic [3:0]  minVelocity;
      logic [10:0] securePosition;
      logic        shaft;
      logic [3:0]  acceleration;
      logic [1:0]  stepResolution;
      logic        trimLockBit;
      logic        configLockBit;
   } lsr_param_t;

   // Protected identifier: two parity bits over the 6-bit id
   function automatic logic [7:0] pid_of(input logic [5:0] id);
      pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction

   // Classic checksum step: add with end-around carry
   function automatic logic [7:0] csum_add(input logic [7:0] s, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, s} + {1'b0, b};
      csum_add = t[7:0] + {7'h00, t[8]};
   endfunction

endpackage

// [verif/lin_status_otp_readout_tb.sv]
// Bench joining master and slave ends, checking answers against field maps
`timescale 1ns/1ns
module lin_status_otp_readout_tb;
   logic                 ref_clk, nrst, reqValid, reqParam, reqLong, reqSecond, reqReady;
   logic                 rspValid, rspGood, rspNoAnswer, rspIsSecond, clearFlags, pendingRead;
   logic [6:0]           reqAddr, nodeAddr;
   logic [5:0]           dirId;
   logic [2:0]           pins;
   logic [63:0]          rspData;
   int                   num_errors, samples_checked, clears;
   lsr_pkg::lsr_status_t st;
   lsr_pkg::lsr_param_t  pm;

   lsr_link_if link ();
   lsr_master lsr_master_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link.master),
      .reqValid(reqValid), .reqParam(reqParam), .reqLong(reqLong), .reqSecond(reqSecond),
      .reqAddr(reqAddr), .reqDirectId(dirId), .reqReady(reqReady), .rspValid(rspValid),
      .rspGood(rspGood), .rspNoAnswer(rspNoAnswer), .rspIsSecond(rspIsSecond), .rspData(rspData));
   lsr_slave lsr_slave_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link.slave),
      .nodeAddr(nodeAddr), .directId(dirId), .status(st), .param(pm), .addressPinState(pins),
      .clearFlags(clearFlags), .pendingRead(pendingRead));
   lsr_assertions lsr_assertions_inst (.ref_clk(ref_clk), .nrst(nrst),
      .hdrValid(link.hdrValid), .hdrPid(link.hdrPid), .mByteValid(link.mByteValid),
      .mByteData(link.mByteData), .sByteValid(link.sByteValid), .sByteData(link.sByteData));

   // Free-running system clock
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Flag-clear pulses, counted for comparison
   always @(posedge ref_clk) begin
      if (clearFlags === 1'h1) clears++;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits for one answer at the user port; a lost answer counts as a mismatch
   task automatic get_rsp();
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (rspValid !== 1'h1 && n < 300);
      if (n >= 300) num_errors++;
   endtask
   // One read: preparing frame, then one or two reading frames
   task automatic run(input logic [2:0] m, input logic [6:0] a, input logic [63:0] e1, e2);
      logic ok;
      ok = (a == nodeAddr);
      @(posedge ref_clk);
      {reqParam, reqLong, reqSecond} <= m;
      reqAddr <= a;
      reqValid <= 1'h1;
      do @(negedge ref_clk); while (reqReady !== 1'h1);
      @(posedge ref_clk);
      reqValid <= 1'h0;
      get_rsp();
      cmp({rspGood, rspNoAnswer, rspIsSecond}, {ok, !ok, 1'h0});
      if (ok) cmp(rspData, e1);
      if (ok && m == 3'h3) begin
         get_rsp();
         cmp({rspGood, rspNoAnswer, rspIsSecond}, 3'h5);
         cmp(rspData, e2);
      end
      $display("test done at %0t", $time);
   endtask

   function automatic logic [63:0] fs1();
      fs1 = {1'h1, nodeAddr, st[85:54], st[53:48], 1'h1, st[47], 4'hF, st[46:43], 8'hFF};
   endfunction
   function automatic logic [63:0] fs2();
      fs2 = {1'h1, nodeAddr, st.actualPosition, st.targetPosition, st.securePosition[7:0],
         5'h1F, st.securePosition[10:8], 8'hFF};
   endfunction
   function automatic logic [63:0] pmx();
      pmx = {pm[55:48], 1'h1, pm[47:41], pm.addressModeBit, pins, pm.programmedAddress,
         pm[35:20], pm.securePosition[10:8], pm.shaft, pm.acceleration,
         pm.securePosition[7:0], 4'hF, pm.stepResolution, pm.trimLockBit, pm.configLockBit};
   endfunction

   // Hang guard, well beyond the fewer than two hundred cycles the reads need
   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      {nrst, reqValid, reqParam, reqLong, reqSecond} = 5'h00;
      {num_errors, samples_checked, clears} = '0;
      reqAddr = 7'h00;
      nodeAddr = 7'h5A;
      dirId = 6'h05;
      pins = 3'h5;
      st = 86'h2A5C396E1AB3D4C2E1F087;
      pm = 56'h9E3B71C5A2D648;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'h1;
      run(3'h3, nodeAddr, fs1(), fs2());
      cmp(64'(clears), 64'h1);
      run(3'h2, nodeAddr, fs1(), 64'h0);
      cmp(64'(pendingRead), 64'h1);
      run(3'h0, nodeAddr, fs1(), 64'h0);
      // Pins must have settled before the expected image is built
      @(posedge ref_clk);
      pins <= 3'h2;
      @(posedge ref_clk);
      run(3'h4, nodeAddr, pmx(), 64'h0);
      run(3'h6, nodeAddr, pmx(), 64'h0);
      run(3'h3, 7'h11, 64'h0, 64'h0);
      cmp(64'(pendingRead), 64'h0);
      cmp(64'(clears), 64'h3);
      report_and_stop();
   end
endmodule

// [verif/lsr_assertions.sv]
// Concurrent checks on the link that joins master and slave ends
`timescale 1ns/1ns
module lsr_assertions (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       hdrValid,
   input wire logic [7:0] hdrPid,
   input wire logic       mByteValid,
   input wire logic [7:0] mByteData,
   input wire logic       sByteValid,
   input wire logic [7:0] sByteData
);
   logic [7:0] sum_r;
   logic [3:0] cnt_r;
   logic [8:0] sumWide;
   logic       isLong;
   logic       isShort;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // Header kinds seen on the link
   assign isLong = hdrValid && hdrPid == lsr_pkg::PID_PREP;
   assign isShort = hdrValid && hdrPid != lsr_pkg::PID_PREP && hdrPid != lsr_pkg::PID_READ;
   assign sumWide = {1'h0, sum_r} + {1'h0, sByteData};

   // Running sum of answer bytes, end-around carry folded each step
   always_ff @(posedge ref_clk) begin
      if (!nrst || !sByteValid) begin
         sum_r <= 8'h00;
         cnt_r <= 4'h0;
      end else begin
         sum_r <= sumWide[7:0] + {7'h00, sumWide[8]};
         cnt_r <= cnt_r + 4'h1;
      end
   end

   sequence s_nine_bytes;
      mByteValid[*8] ##1 mByteValid ##1 !mByteValid;
   endsequence
   sequence s_flagged_pair;
      mByteData[7] ##1 mByteData[7];
   endsequence

   a_long_prep_len: assert property (isLong |=> s_nine_bytes)
      else $error("long preparing frame length wrong");
   a_long_prep_head: assert property (isLong |=> mByteData == lsr_pkg::APP_CMD ##1 s_flagged_pair)
      else $error("long preparing frame head wrong");
   a_long_fill: assert property (isLong |-> ##4 (mByteData == lsr_pkg::FILL_BYTE)[*5])
      else $error("long preparing frame fill wrong");
   a_short_prep_len: assert property (isShort |=> mByteValid[*3] ##1 !mByteValid)
      else $error("short preparing frame length wrong");
   a_short_flags: assert property (isShort |=> s_flagged_pair)
      else $error("short preparing frame flag bits wrong");
   a_pid_parity: assert property (isShort |-> hdrPid[7:6] == {~(hdrPid[1] ^ hdrPid[3]
      ^ hdrPid[4] ^ hdrPid[5]), hdrPid[0] ^ hdrPid[1] ^ hdrPid[2] ^ hdrPid[4]})
      else $error("identifier parity wrong");
   a_answer_cause: assert property ($rose(sByteValid) |-> $past(hdrValid && hdrPid == lsr_pkg::PID_READ, 2))
      else $error("answer without reading header");
   a_answer_len: assert property ($rose(sByteValid) |=> sByteValid[*8] ##1 !sByteValid)
      else $error("answer length wrong");
   a_answer_sum: assert property (sByteValid && cnt_r == 4'h8 |-> sByteData == ~sum_r)
      else $error("answer checksum wrong");
   a_no_collide: assert property (sByteValid |-> !mByteValid && !hdrValid)
      else $error("master drives during answer");
endmodule
